/* core/multi_board_sync_sequencer.v */
`timescale 1ns/1ps
`include "sync_seq_regs.vh"

// Function
// - clock-follower code sets the follower role for standard mode
// - arm code arms the board for synchronized operation
// - run code starts the board with current register settings
// - blocking-run code starts interrupt-driven; caller waits until stopped
// - board reports finished when run ends; software waits for all
// - repeat run needs only re-arm and restart
module multi_board_sync_sequencer (
    // ahb-lite slave
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    // group sync pins
    input wire group_arm_in,
    input wire run_stop_in,
    output reg group_arm_out,
    output reg running,
    output reg clock_follower,
    output reg blocking_busy
);

    localparam ST_IDLE = 2'h0;
    localparam ST_ARMED = 2'h1;
    localparam ST_RUN = 2'h2;
    localparam ST_DONE = 2'h3;
    localparam SYNC_PINS = 2;

    // sequencer state
    reg [1:0] state;
    reg [1:0] next_state;
    // software registers and run counter
    reg [31:0] command_register;
    reg [31:0] run_length;
    reg [31:0] run_count;
    // roles and flags
    reg clk_leader;
    reg trig_leader;
    reg trig_follower;
    reg blocking;
    reg finished;
    // bus data phase
    reg wr_pend;
    reg [11:0] wr_addr;
    // group pins
    reg arm_pulse_seen;
    wire [SYNC_PINS-1:0] pin_raw;
    wire [SYNC_PINS-1:0] pin_sync;

    // register offset match, shared by read and write paths
    function addr_hit;
        input [11:0] addr;
        input [11:0] offset;
        begin
            addr_hit = (addr == offset);
        end
    endfunction

    // command code match
    function code_hit;
        input [31:0] data;
        input [31:0] code;
        begin
            code_hit = (data == code);
        end
    endfunction

    wire addr_phase = hsel && hready && htrans[1];
    wire cmd_wr = wr_pend && addr_hit(wr_addr, `OFS_COMMAND);
    wire len_wr = wr_pend && addr_hit(wr_addr, `OFS_RUN_LENGTH);
    wire cmd_arm = cmd_wr && code_hit(hwdata, `CMD_ARM_GROUP);
    wire cmd_run = cmd_wr && code_hit(hwdata, `CMD_RUN);
    wire cmd_brun = cmd_wr && code_hit(hwdata, `CMD_BLOCKING_RUN);
    wire cmd_cfol = cmd_wr && code_hit(hwdata, `CMD_CLOCK_FOLLOWER);
    wire cmd_clead = cmd_wr && code_hit(hwdata, `CMD_CLOCK_LEADER);
    wire cmd_tfol = cmd_wr && code_hit(hwdata, `CMD_TRIGGER_FOLLOWER);
    wire cmd_tlead = cmd_wr && code_hit(hwdata, `CMD_TRIGGER_LEADER);
    wire arm_level = pin_sync[0];
    wire stop_level = pin_sync[1];
    wire ext_arm = arm_level && !arm_pulse_seen;
    wire can_arm = (state == ST_IDLE) || (state == ST_DONE);
    wire arm_any = (cmd_arm || ext_arm) && can_arm;
    wire start = (state == ST_ARMED) && (cmd_run || cmd_brun);
    wire run_end = (state == ST_RUN) && ((run_count == 32'h00000001) || stop_level);

    assign pin_raw = {run_stop_in, group_arm_in};

    // two-stage synchronisers for the group pins
    genvar i;
    generate
        for (i = 0; i < SYNC_PINS; i = i + 1)
        begin : g_sync
            reg meta;
            reg stable;
            always @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    meta <= 1'b0;
                    stable <= 1'b0;
                end
                else
                begin
                    meta <= pin_raw[i];
                    stable <= meta;
                end
            end
            assign pin_sync[i] = stable;
        end
    endgenerate

    // rising edge of the synchronised arm line
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            arm_pulse_seen <= 1'b0;
        else
            arm_pulse_seen <= arm_level;
    end

    function [31:0] status_word;
        input [1:0] st;
        input cf;
        input cl;
        input tf;
        input tl;
        input fin;
        input blk;
        begin
            status_word = 32'h00000000;
            status_word[`ST_CLOCK_FOLLOWER] = cf;
            status_word[`ST_CLOCK_LEADER] = cl;
            status_word[`ST_ARMED] = (st == ST_ARMED);
            status_word[`ST_RUNNING] = (st == ST_RUN);
            status_word[`ST_FINISHED] = fin;
            status_word[`ST_BLOCKING] = blk;
            status_word[`ST_TRIG_FOLLOWER] = tf;
            status_word[`ST_TRIG_LEADER] = tl;
        end
    endfunction

    // sequencer next state
    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (arm_any)
                    next_state = ST_ARMED;
            end
            ST_ARMED:
            begin
                if (start)
                    next_state = ST_RUN;
            end
            ST_RUN:
            begin
                if (run_end)
                    next_state = ST_DONE;
            end
            default:
            begin
                if (arm_any)
                    next_state = ST_ARMED;
                else
                    next_state = ST_IDLE;
            end
        endcase
    end

    // sequencer state register
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // bus slave: zero wait states, always okay
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend <= addr_phase && hwrite;
            wr_addr <= haddr[11:0];
            if (addr_phase && !hwrite)
            begin
                if (addr_hit(haddr[11:0], `OFS_COMMAND))
                    hrdata <= command_register;
                else if (addr_hit(haddr[11:0], `OFS_STATUS))
                    hrdata <= status_word(state, clock_follower, clk_leader, trig_follower, trig_leader,
                        finished, blocking);
                else if (addr_hit(haddr[11:0], `OFS_RUN_LENGTH))
                    hrdata <= run_length;
                else
                    hrdata <= 32'h00000000;
            end
            else
                hrdata <= 32'h00000000;
        end
    end

    // writable registers
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            command_register <= 32'h00000000;
            run_length <= `RUN_LENGTH_RESET;
        end
        else
        begin
            if (cmd_wr)
                command_register <= hwdata;
            if (len_wr)
                run_length <= hwdata;
        end
    end

    // clock and trigger roles
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            clk_leader <= 1'b0;
            clock_follower <= 1'b0;
            trig_leader <= 1'b0;
            trig_follower <= 1'b0;
        end
        else
        begin
            if (cmd_cfol)
            begin
                clock_follower <= 1'b1;
                clk_leader <= 1'b0;
            end
            else if (cmd_clead)
            begin
                clk_leader <= 1'b1;
                clock_follower <= 1'b0;
            end
            if (cmd_tfol)
            begin
                trig_follower <= 1'b1;
                trig_leader <= 1'b0;
            end
            else if (cmd_tlead)
            begin
                trig_leader <= 1'b1;
                trig_follower <= 1'b0;
            end
        end
    end

    // run control; a run end beats a clear in the same cycle
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            run_count <= 32'h00000000;
            blocking <= 1'b0;
            finished <= 1'b0;
            group_arm_out <= 1'b0;
            running <= 1'b0;
            blocking_busy <= 1'b0;
        end
        else
        begin
            // arm drives the group line from this board
            group_arm_out <= cmd_arm && can_arm;
            if (start)
            begin
                run_count <= (run_length == 32'h00000000) ? 32'h00000001 : run_length;
                blocking <= cmd_brun;
                running <= 1'b1;
                blocking_busy <= cmd_brun;
            end
            else if (state == ST_RUN)
            begin
                run_count <= run_count - 32'h00000001;
                if (run_end)
                begin
                    running <= 1'b0;
                    blocking_busy <= 1'b0;
                    finished <= 1'b1;
                end
            end
            else if (arm_any)
                finished <= 1'b0;
        end
    end

endmodule // multi_board_sync_sequencer

/* core/sync_seq_regs.vh */
`ifndef SYNC_SEQ_REGS_VH
`define SYNC_SEQ_REGS_VH
// register byte offsets
`define OFS_COMMAND 12'h000
`define OFS_STATUS 12'h004
`define OFS_RUN_LENGTH 12'h008
// command codes
`define CMD_RUN 32'h0000000A
`define CMD_BLOCKING_RUN 32'h0000000B
`define CMD_CLOCK_LEADER 32'h00000064
`define CMD_TRIGGER_LEADER 32'h00000065
`define CMD_CLOCK_FOLLOWER 32'h0000006E
`define CMD_TRIGGER_FOLLOWER 32'h0000006F
`define CMD_ARM_GROUP 32'h00000082
// status fields
`define ST_CLOCK_FOLLOWER 0
`define ST_CLOCK_LEADER 1
`define ST_ARMED 2
`define ST_RUNNING 3
`define ST_FINISHED 4
`define ST_BLOCKING 5
`define ST_TRIG_FOLLOWER 6
`define ST_TRIG_LEADER 7
// reset values
`define RUN_LENGTH_RESET 32'h00000010
`endif

/* dv/multi_board_sync_sequencer_bench.sv */
`timescale 1ns/1ps
`include "sync_seq_regs.vh"
module multi_board_sync_sequencer_bench;
    logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, arm_req = 1'b0, stop_req = 1'b0;
    logic [31:0] haddr = 0, hwdata = 0;
    logic [1:0] htrans = 0;
    wire hreadyout, hresp, group_arm_in, run_stop_in, group_arm_out, running, clock_follower, blocking_busy;
    wire [31:0] hrdata;
    int err_count = 0, check_count = 0, len, n;
    always #5 hclk = ~hclk;
    multi_board_sync_sequencer i_multi_board_sync_sequencer (.hsel(1'b1), .hsize(3'h2), .hready(hreadyout), .*);
    peer_board i_peer_board (.*);
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        err_count += seen !== exp;
        if (seen !== exp) $display("Error %0t: %h not %h", $time, seen, exp);
    endtask
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] m = 0);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        if (!w) check(hrdata & m, d);
    endtask
    task runs(input int k);
        n = 0;
        repeat (k)
        begin
            @(posedge hclk);
            n += running === 1'b1;
        end
    endtask
    task print_verdict(input int tmo);
        err_count += tmo;
        $display("%0d checks %0d errors", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial #100000 print_verdict(1);
    initial
    begin
        void'($urandom(32'h9CDF2051));
        len = 12 + $urandom % 16;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(0, 32'h8, `RUN_LENGTH_RESET, ~0);
        bus(1, 32'h0, `CMD_CLOCK_FOLLOWER);
        bus(1, 32'h0, `CMD_TRIGGER_FOLLOWER);
        check(clock_follower, 1);
        bus(0, 32'h4, 32'h41, 32'h43);
        bus(1, 32'h0, `CMD_RUN);
        runs(4);
        check(n, 0);
        bus(1, 32'h8, len);
        bus(1, 32'h0, `CMD_ARM_GROUP);
        bus(1, 32'h0, `CMD_RUN);
        runs(40);
        check(n, len);
        bus(0, 32'h4, 32'h10, 32'h34);
        arm_req <= 1'b1;
        @(posedge hclk);
        arm_req <= 1'b0;
        repeat (6) @(posedge hclk);
        bus(1, 32'h0, `CMD_BLOCKING_RUN);
        bus(1, 32'h0, `CMD_ARM_GROUP);
        stop_req <= 1'b1;
        runs(40);
        check(n < 8, 1);
        stop_req <= 1'b0;
        bus(0, 32'h4, 32'h30, 32'h34);
        bus(1, 32'h0, `CMD_ARM_GROUP);
        bus(1, 32'h0, `CMD_RUN);
        runs(40);
        check(n, len);
        print_verdict(0);
    end
endmodule // multi_board_sync_sequencer_bench

/* dv/peer_board.sv */
`timescale 1ns/1ps
module peer_board (
    // bench side
    input wire hclk,
    input wire arm_req,
    input wire stop_req,
    // group pins
    output reg group_arm_in = 1'b0,
    output reg run_stop_in = 1'b0
);
    // lone clock leader arms the group on request
    always @(posedge hclk)
    begin
        group_arm_in <= arm_req;
        run_stop_in <= stop_req;
    end
endmodule // peer_board

/* dv/sync_seq_props.sv */
`timescale 1ns/1ps
module sync_seq_props (
    // bus
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    // group
    input wire group_arm_in,
    input wire group_arm_out,
    input wire running,
    input wire clock_follower,
    input wire blocking_busy
);
    reg wr;
    reg arm_m;
    wire [31:0] c = wr ? hwdata : 32'h0;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    always @(posedge hclk) wr <= hsel & hready & htrans[1] & hwrite & (haddr[11:0] == 12'h000);
    always @(posedge hclk) arm_m <= hresetn & (group_arm_in | group_arm_out | (arm_m & !$fell(running)));
    AST_FOL: assert property (c == 32'h6E |-> ##[1:2] clock_follower) else $error("role");
    AST_ARM: assert property (c == 32'h82 && !running && !arm_m |-> ##[1:2] group_arm_out) else $error("arm");
    AST_PULSE: assert property ($rose(group_arm_out) |=> !group_arm_out) else $error("pulse");
    AST_NOARM: assert property (c == 32'h82 && running |=> !group_arm_out [*2]) else $error("rearm");
    AST_RUN: assert property (c == 32'h0A && arm_m && !running |-> ##[1:2] running) else $error("run");
    AST_IDLE: assert property (c == 32'h0A && !arm_m |=> !running [*3]) else $error("idle");
    AST_BLK: assert property (c == 32'h0B && arm_m && !running |-> ##[1:2] blocking_busy) else $error("blk");
    AST_BLK_END: assert property ($fell(running) |-> !blocking_busy) else $error("blkend");
    AST_OKAY: assert property (hreadyout && !hresp) else $error("okay");
endmodule // sync_seq_props

bind multi_board_sync_sequencer sync_seq_props i_props (.*);
